// ===== verilog/standby_pkg.sv
`default_nettype none
package standby_pkg;
   // Standby state codes, one-hot
   localparam logic [3:0] ST_RUN = 4'h1;
   localparam logic [3:0] ST_HALT = 4'h2;
   localparam logic [3:0] ST_STOP = 4'h4;
   localparam logic [3:0] ST_WAIT = 4'h8;
   // Power-on status register
   localparam logic [11:0] POWER_ON_STATUS_ADDR = 12'hFD1;
   localparam int POWER_ON_LATCH_BIT = 0;
   localparam logic [3:0] POWER_ON_STATUS_RESET = 4'h0;
   // Wait selections, in basic timer ticks (2^n reference)
   localparam logic [15:0] WAIT_SEL0 = 16'h0010;
   localparam logic [15:0] WAIT_SEL1 = 16'h0100;
   localparam logic [15:0] WAIT_SEL2 = 16'h1000;
   localparam logic [15:0] WAIT_SEL3 = 16'hFFFF;
   // Oscillator start-up delay, cycles before counting starts
   localparam logic [7:0] OSC_START_CYCLES = 8'h08;
   // Power-on pulse length in cycles
   localparam logic [7:0] POR_PULSE_CYCLES = 8'h10;
   // Clock source selections for peripherals
   typedef enum logic [1:0] {
      SRC_CPU = 2'h0,
      SRC_INTERNAL = 2'h1,
      SRC_EXT_PIN = 2'h2,
      SRC_TIMER0 = 2'h3
   } clk_src_e;
   typedef struct packed {
      clk_src_e serial_src;
      logic timer0_ext;
      logic timer1_ext;
      clk_src_e clkout_src;
      logic clkout_on;
   } periph_cfg_s;
   typedef struct packed {
      logic cpu;
      logic osc;
      logic interval;
      logic serial;
      logic timer0;
      logic timer1;
      logic clkout;
   } run_en_s;
endpackage
`default_nettype wire

// ===== verilog/standby_and_reset_control.sv
// Operation
// - STOP instruction halts oscillator and all internally clocked logic
// - HALT gates only CPU clock
// - Interval timer runs in HALT, frozen in STOP
// - Serial in STOP only on external clocks
// - Serial in HALT unless CPU-clocked
// - Counters in STOP only on event pin
// - Clock output stops in STOP, non-CPU in HALT
// - Enabled interrupt or reset ends standby
// - Wake waits selectable interval before resuming
// - Power-on circuit makes internal reset pulse
// - Two mask switches route pulse three ways
// - Power-on latch set only by power-on pulse
// - Latch at bit 0 of FD1H
// - Bit-set instruction cannot set the latch
// - Wait counted from oscillation start
`timescale 1ns/1ps
`default_nettype none
module standby_and_reset_control (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic power_rise,
   input wire logic mask_switch_a,
   input wire logic mask_switch_b,
   input wire logic reset_pin_n,
   input wire logic stop_exec,
   input wire logic halt_exec,
   input wire logic [6:0] irq_request,
   input wire logic [6:0] interrupt_enable_flag,
   input wire logic [1:0] wait_sel,
   input wire logic interval_tick,
   input wire standby_pkg::periph_cfg_s periph_cfg,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic bit_set_instruction,
   input wire logic [11:0] mem_addr,
   input wire logic [3:0] mem_wdata,
   output logic [3:0] mem_rdata,
   output logic internal_reset_signal,
   output standby_pkg::run_en_s run_en,
   output logic interval_timer_request,
   output logic [6:0] wake_irq,
   output logic wake_valid
);
   import standby_pkg::*;

   typedef enum logic [3:0] {
      S_RUN = ST_RUN,
      S_HALT = ST_HALT,
      S_STOP = ST_STOP,
      S_WAIT = ST_WAIT
   } mode_e;

   function automatic logic [15:0] wait_len(input logic [1:0] sel);
      logic [15:0] r;
      r = WAIT_SEL0;
      unique case (sel)
         2'h0: r = WAIT_SEL0;
         2'h1: r = WAIT_SEL1;
         2'h2: r = WAIT_SEL2;
         2'h3: r = WAIT_SEL3;
      endcase
      return r;
   endfunction

   mode_e mode_r, mode_nxt;
   logic [15:0] wait_cnt_r, wait_cnt_nxt;
   logic [7:0] osc_cnt_r, osc_cnt_nxt;
   logic [7:0] por_cnt_r, por_cnt_nxt;
   logic por_active_r, por_active_nxt;
   logic latch_r, latch_nxt;
   logic [3:0] rdata_r, rdata_nxt;
   logic ires_r, ires_nxt;
   run_en_s run_r, run_nxt;
   logic itr_r, itr_nxt;
   logic [6:0] wirq_r, wirq_nxt;
   logic wvalid_r, wvalid_nxt;
   logic [6:0] pend;
   logic por_pulse, por_to_reset, por_to_latch, any_reset;

   assign pend = irq_request & interrupt_enable_flag;

   // Power-on pulse generator and mask routing
   always_comb begin
      por_cnt_nxt = por_cnt_r;
      por_active_nxt = por_active_r;
      if (power_rise) begin
         por_active_nxt = 1'b1;
         por_cnt_nxt = POR_PULSE_CYCLES;
      end else if (por_active_r) begin
         if (por_cnt_r <= 8'h01) begin
            por_active_nxt = 1'b0;
            por_cnt_nxt = 8'h00;
         end else begin
            por_cnt_nxt = por_cnt_r - 8'h01;
         end
      end
   end
   assign por_pulse = por_active_r;
   // Route: A reaches reset, B reaches the latch; both off disables
   assign por_to_reset = por_pulse & mask_switch_a;
   assign por_to_latch = por_pulse & mask_switch_b;
   assign any_reset = por_to_reset | ~reset_pin_n;

   // Power-on latch at FD1H bit 0; writes may only clear it
   always_comb begin
      latch_nxt = latch_r;
      rdata_nxt = rdata_r;
      if (mem_wr && mem_addr == POWER_ON_STATUS_ADDR &&
          !bit_set_instruction && !mem_wdata[POWER_ON_LATCH_BIT])
         latch_nxt = 1'b0;
      if (por_to_latch)
         latch_nxt = 1'b1;
      if (mem_rd && mem_addr == POWER_ON_STATUS_ADDR)
         rdata_nxt = {3'h0, latch_r};
      else if (mem_rd)
         rdata_nxt = POWER_ON_STATUS_RESET;
   end

   // Standby sequencer
   always_comb begin
      mode_nxt = mode_r;
      wait_cnt_nxt = wait_cnt_r;
      osc_cnt_nxt = osc_cnt_r;
      wirq_nxt = 7'h00;
      wvalid_nxt = 1'b0;
      ires_nxt = any_reset;
      if (any_reset) begin
         // Reset also releases standby, then waits from oscillation
         mode_nxt = S_WAIT;
         osc_cnt_nxt = OSC_START_CYCLES;
         wait_cnt_nxt = wait_len(wait_sel);
      end else begin
         unique case (mode_r)
            S_RUN: begin
               if (stop_exec) begin
                  mode_nxt = S_STOP;
               end else if (halt_exec) begin
                  mode_nxt = S_HALT;
               end
            end
            S_HALT, S_STOP: begin
               if (|pend) begin
                  mode_nxt = S_WAIT;
                  osc_cnt_nxt = (mode_r == S_STOP) ?
                     OSC_START_CYCLES : 8'h00;
                  wait_cnt_nxt = wait_len(wait_sel);
               end
            end
            S_WAIT: begin
               if (osc_cnt_r != 8'h00) begin
                  osc_cnt_nxt = osc_cnt_r - 8'h01;
               end else if (wait_cnt_r != 16'h0000) begin
                  if (interval_tick)
                     wait_cnt_nxt = wait_cnt_r - 16'h0001;
               end else begin
                  mode_nxt = S_RUN;
                  wirq_nxt = pend;
                  wvalid_nxt = |pend;
               end
            end
            default: mode_nxt = S_RUN;
         endcase
      end
   end

   // Clock enables for each mode
   always_comb begin
      run_nxt = '0;
      itr_nxt = 1'b0;
      unique case (mode_nxt)
         S_RUN: begin
            run_nxt = '1;
            run_nxt.clkout = periph_cfg.clkout_on;
            itr_nxt = interval_tick;
         end
         S_HALT: begin
            run_nxt.osc = 1'b1;
            run_nxt.interval = 1'b1;
            itr_nxt = interval_tick;
            run_nxt.serial = periph_cfg.serial_src != SRC_CPU;
            run_nxt.timer0 = 1'b1;
            run_nxt.timer1 = 1'b1;
            run_nxt.clkout = periph_cfg.clkout_on &&
               periph_cfg.clkout_src != SRC_CPU;
         end
         S_STOP: begin
            // Oscillator off, only externally clocked logic moves
            run_nxt.serial = periph_cfg.serial_src == SRC_EXT_PIN ||
               (periph_cfg.serial_src == SRC_TIMER0 &&
                periph_cfg.timer0_ext);
            run_nxt.timer0 = periph_cfg.timer0_ext;
            run_nxt.timer1 = periph_cfg.timer1_ext;
         end
         S_WAIT: begin
            // Timer must run to count the wait once oscillating
            run_nxt.osc = 1'b1;
            run_nxt.interval = 1'b1;
         end
         default: run_nxt = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= S_RUN;
         wait_cnt_r <= 16'h0000;
         osc_cnt_r <= 8'h00;
         por_cnt_r <= 8'h00;
         por_active_r <= 1'b0;
         latch_r <= 1'b0;
         rdata_r <= POWER_ON_STATUS_RESET;
         ires_r <= 1'b0;
         run_r <= '0;
         itr_r <= 1'b0;
         wirq_r <= 7'h00;
         wvalid_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         wait_cnt_r <= wait_cnt_nxt;
         osc_cnt_r <= osc_cnt_nxt;
         por_cnt_r <= por_cnt_nxt;
         por_active_r <= por_active_nxt;
         latch_r <= latch_nxt;
         rdata_r <= rdata_nxt;
         ires_r <= ires_nxt;
         run_r <= run_nxt;
         itr_r <= itr_nxt;
         wirq_r <= wirq_nxt;
         wvalid_r <= wvalid_nxt;
      end
   end

   assign mem_rdata = rdata_r;
   assign internal_reset_signal = ires_r;
   assign run_en = run_r;
   assign interval_timer_request = itr_r;
   assign wake_irq = wirq_r;
   assign wake_valid = wvalid_r;

   default clocking chk_clk @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   stop_osc_off_a: assert property (
      mode_r == S_STOP |-> !run_r.osc && !run_r.cpu && !run_r.clkout)
      else $error("oscillator running in stop");
   halt_cpu_only_a: assert property (
      mode_r == S_HALT |-> run_r.osc && !run_r.cpu && run_r.timer0)
      else $error("halt gating wrong");
   halt_tick_a: assert property (
      $past(mode_nxt) == S_HALT && $past(interval_tick)
      |-> interval_timer_request)
      else $error("interval request lost in halt");
   stop_tick_a: assert property (
      mode_r == S_STOP |-> !interval_timer_request && !run_r.interval)
      else $error("interval timer runs in stop");
   stop_serial_a: assert property (
      mode_r == S_STOP && run_r.serial
      |-> $past(periph_cfg.serial_src) != SRC_CPU)
      else $error("serial runs on cpu clock in stop");
   halt_serial_a: assert property (
      mode_r == S_HALT
      |-> run_r.serial == ($past(periph_cfg.serial_src) != SRC_CPU))
      else $error("serial gating wrong in halt");
   stop_timer_a: assert property (
      mode_r == S_STOP |-> run_r.timer1 == $past(periph_cfg.timer1_ext))
      else $error("timer1 gating wrong in stop");
   halt_clkout_a: assert property (
      mode_r == S_HALT |-> run_r.clkout == ($past(periph_cfg.clkout_on)
      && $past(periph_cfg.clkout_src) != SRC_CPU))
      else $error("clock output gating wrong in halt");
   wake_irq_a: assert property (
      (mode_r == S_HALT) && (|pend) && reset_pin_n && !por_to_reset
      |=> mode_r == S_WAIT)
      else $error("no wake on enabled interrupt");
   pin_reset_a: assert property (
      !reset_pin_n |=> internal_reset_signal && mode_r == S_WAIT)
      else $error("reset pin did not end standby");
   wait_hold_a: assert property (
      mode_r == S_WAIT && wait_cnt_r != 16'h0000 |=> mode_r == S_WAIT)
      else $error("wait left before count ran out");
   por_pulse_a: assert property (
      power_rise |=> por_active_r && por_cnt_r == POR_PULSE_CYCLES)
      else $error("no power-on pulse on supply rise");
   latch_set_a: assert property (
      !latch_r ##1 latch_r |-> $past(por_to_latch))
      else $error("latch set without power-on");
   latch_read_a: assert property (
      mem_rd && mem_addr == POWER_ON_STATUS_ADDR
      |=> mem_rdata == {3'h0, $past(latch_r)})
      else $error("latch read back wrong");
   sequence osc_phase_s;
      mode_r == S_WAIT && osc_cnt_r != 8'h00;
   endsequence
   osc_first_a: assert property (
      osc_phase_s |-> wait_cnt_r == $past(wait_cnt_r) ||
      $past(mode_r) != S_WAIT || $past(any_reset))
      else $error("wait counted before oscillation");
   // Last wait step: both counts spent and no reset restarting them
   sequence wait_done_s;
      mode_r == S_WAIT && osc_cnt_r == 8'h00 && wait_cnt_r == 16'h0000
      && !any_reset;
   endsequence
   wait_resume_a: assert property (
      wait_done_s |=> mode_r == S_RUN && run_r.cpu &&
      wake_irq == $past(pend))
      else $error("no resume after wait");
endmodule // standby_and_reset_control
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      err_count++; \
      $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
   end \
end
module tb_top;
   import standby_pkg::*;
   logic clk = 0;
   logic rst_n = 0;
   logic power_rise = 0;
   logic mask_switch_a = 0;
   logic mask_switch_b = 0;
   logic reset_pin_n = 1;
   logic stop_exec = 0;
   logic halt_exec = 0;
   logic [6:0] irq_request = 0;
   logic [6:0] interrupt_enable_flag = 0;
   logic [1:0] wait_sel = 0;
   logic interval_tick = 1;
   periph_cfg_s periph_cfg = '{SRC_EXT_PIN, 1'b1, 1'b0, SRC_INTERNAL, 1'b1};
   logic mem_wr = 0;
   logic mem_rd = 0;
   logic bit_set_instruction = 0;
   logic [11:0] mem_addr = 0;
   logic [3:0] mem_wdata = 0;
   logic [3:0] mem_rdata;
   logic internal_reset_signal;
   run_en_s run_en;
   logic interval_timer_request;
   logic [6:0] wake_irq;
   logic wake_valid;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int cnt;
   logic [3:0] exp_q[$];
   logic [3:0] e;
   logic [6:0] irq_bit;
   logic rd_p = 0;
   logic rd_q = 0;
   always #5 clk = ~clk;
   standby_and_reset_control dut (.clk(clk), .rst_n(rst_n),
      .power_rise(power_rise), .mask_switch_a(mask_switch_a),
      .mask_switch_b(mask_switch_b), .reset_pin_n(reset_pin_n),
      .stop_exec(stop_exec), .halt_exec(halt_exec),
      .irq_request(irq_request),
      .interrupt_enable_flag(interrupt_enable_flag), .wait_sel(wait_sel),
      .interval_tick(interval_tick), .periph_cfg(periph_cfg),
      .mem_wr(mem_wr), .mem_rd(mem_rd),
      .bit_set_instruction(bit_set_instruction), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .internal_reset_signal(internal_reset_signal), .run_en(run_en),
      .interval_timer_request(interval_timer_request),
      .wake_irq(wake_irq), .wake_valid(wake_valid));
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [3:0] x);
      exp_q.push_back(x);
      mem_addr = a;
      mem_rd = 1;
      step(1);
      mem_rd = 0;
      step(1);
   endtask
   task automatic wr(input logic [3:0] d, input logic b);
      mem_addr = POWER_ON_STATUS_ADDR;
      mem_wdata = d;
      bit_set_instruction = b;
      mem_wr = 1;
      step(1);
      mem_wr = 0;
      bit_set_instruction = 0;
      step(1);
   endtask
   task automatic wait_run;
      cnt = 0;
      while (run_en.cpu !== 1'b1 && cnt < 3000) begin
         step(1);
         cnt++;
      end
      `CHK("resume", 1'b1, run_en.cpu)
   endtask
   task automatic wake_wait;
      cnt = 0;
      while (wake_valid !== 1'b1 && cnt < 300) begin
         step(1);
         cnt++;
      end
      `CHK("wake_valid", 1'b1, wake_valid)
      `CHK("wake_irq", irq_bit, wake_irq)
   endtask
   task automatic enter(input logic stop);
      stop_exec = stop;
      halt_exec = !stop;
      step(1);
      stop_exec = 0;
      halt_exec = 0;
      step(1);
   endtask
   // Read data lands one edge after the read is taken
   always @(posedge clk) begin
      rd_q <= rd_p;
      rd_p <= mem_rd;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         complete_run();
      end
   end
   always @(negedge clk) begin
      if (rd_q) begin
         e = exp_q.pop_front();
         `CHK("rdata", e, mem_rdata)
      end
   end
   initial begin
      void'($urandom(32'hd44a743f));
      step(10);
      rst_n = 1;
      wait_run();
      rd(POWER_ON_STATUS_ADDR, POWER_ON_STATUS_RESET);
      mask_switch_b = 1;
      power_rise = 1;
      step(1);
      power_rise = 0;
      step(20);
      `CHK("no_reset", 1'b0, internal_reset_signal)
      rd(POWER_ON_STATUS_ADDR, 4'h1);
      wr(4'h0, 1'b0);
      rd(POWER_ON_STATUS_ADDR, 4'h0);
      for (int b = 0; b < 2; b++) begin
         wr(4'h1, b[0]);
         rd(POWER_ON_STATUS_ADDR, 4'h0);
      end
      rd(12'($urandom % 4048), 4'h0);
      mask_switch_a = 1;
      mask_switch_b = 0;
      power_rise = 1;
      step(2);
      power_rise = 0;
      `CHK("por_reset", 1'b1, internal_reset_signal)
      wait_run();
      rd(POWER_ON_STATUS_ADDR, 4'h0);
      mask_switch_a = 0;
      enter(1'b0);
      `CHK("halt_cpu", 1'b0, run_en.cpu)
      `CHK("halt_osc", 1'b1, run_en.osc)
      `CHK("halt_bt", 1'b1, run_en.interval)
      `CHK("halt_req", 1'b1, interval_timer_request)
      `CHK("halt_ser", 1'b1, run_en.serial)
      `CHK("halt_tm", 1'b1, run_en.timer1)
      `CHK("halt_clko", 1'b1, run_en.clkout)
      irq_bit = 7'h01 << ($urandom % 7);
      irq_request = irq_bit;
      step(30);
      `CHK("masked", 1'b0, run_en.cpu)
      interrupt_enable_flag = irq_bit;
      wake_wait();
      `CHK("halt_wait", 1'b1, cnt >= 16)
      irq_request = 0;
      interrupt_enable_flag = 0;
      step(2);
      `CHK("run_cpu", 1'b1, run_en.cpu)
      enter(1'b1);
      `CHK("stop_osc", 1'b0, run_en.osc)
      `CHK("stop_cpu", 1'b0, run_en.cpu)
      `CHK("stop_bt", 1'b0, run_en.interval)
      `CHK("stop_req", 1'b0, interval_timer_request)
      `CHK("stop_ser", 1'b1, run_en.serial)
      `CHK("stop_t0", 1'b1, run_en.timer0)
      `CHK("stop_t1", 1'b0, run_en.timer1)
      `CHK("stop_clko", 1'b0, run_en.clkout)
      irq_request = irq_bit;
      interrupt_enable_flag = irq_bit;
      wake_wait();
      `CHK("stop_wait", 1'b1, cnt >= 24)
      irq_request = 0;
      interrupt_enable_flag = 0;
      periph_cfg.serial_src = SRC_CPU;
      periph_cfg.clkout_src = SRC_CPU;
      wait_sel = 2'h1;
      enter(1'b0);
      `CHK("halt_ser_cpu", 1'b0, run_en.serial)
      `CHK("halt_clko_cpu", 1'b0, run_en.clkout)
      reset_pin_n = 0;
      step(2);
      `CHK("pin_reset", 1'b1, internal_reset_signal)
      reset_pin_n = 1;
      wait_run();
      `CHK("sel1_wait", 1'b1, cnt >= 264)
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
